// file: logic/dcc_pkg.sv
// Purpose: shared constants and types of the DMA channel control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   field positions are bit indices of the control, status and go registers
package dcc_pkg;
    localparam logic [7:0]  A_CTRL       = 8'h00;
    localparam logic [7:0]  A_SRC        = 8'h04;
    localparam logic [7:0]  A_DST        = 8'h08;
    localparam logic [7:0]  A_CNT        = 8'h0C;
    localparam logic [7:0]  A_STAT       = 8'h10;
    localparam logic [7:0]  A_GO         = 8'h14;
    localparam int unsigned B_CHAIN_IE   = 11;
    localparam int unsigned B_CORE_IE    = 10;
    localparam int unsigned B_SYS_IE     = 9;
    localparam int unsigned B_SRC_SYS    = 7;
    localparam int unsigned B_SRC_CM     = 4;
    localparam int unsigned B_DST_SYS    = 3;
    localparam int unsigned B_DST_CM     = 0;
    localparam int unsigned S_SYS_ERR    = 0;
    localparam int unsigned S_CORE_ERR   = 1;
    localparam int unsigned S_CHAIN      = 2;
    localparam int unsigned S_CFG_ERR    = 3;
    localparam int unsigned S_ACT        = 31;
    localparam int unsigned B_GO         = 0;
    localparam logic [31:0] CTRL_MASK    = 32'h0000_0EBB;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [1:0]  CM_FIXED     = 2'h0;
    localparam logic [1:0]  CM_RSVD      = 2'h1;
    localparam logic [1:0]  CM_INC       = 2'h2;
    localparam logic [1:0]  CM_DEC       = 2'h3;
    localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
    localparam int unsigned FIFO_DEPTH   = 4;
    localparam int unsigned CNT_W        = 16;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_HALT = 3'h4
    } dcc_state_type;
endpackage

// file: logic/dcc_fifo_if.sv
// Purpose: valid/ready carrier between the channel and its data FIFO
// Assumes: single clock
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
interface dcc_fifo_if #(parameter int unsigned W = 32);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// file: logic/dcc_fifo.sv
// Purpose: small flip-flop FIFO in the channel data path
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from an occupancy count
`timescale 1ns/100ps
`default_nettype none
module dcc_fifo #(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    dcc_fifo_if.fifo f
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign f.in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign f.out_valid = (cnt_q != '0);
    assign f.out_data  = mem_q[rp_q];
    assign push        = f.in_valid & f.in_ready;
    assign pop         = f.out_valid & f.out_ready;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_ent
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mem_q[gi] <= '0;
                else if (push && wp_q == PW'(gi))
                    mem_q[gi] <= f.in_data;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // dcc_fifo
`default_nettype wire

// file: logic/dcc_step.sv
// Purpose: next address after one word, from a counting mode
// Assumes: word-sized transfers
// Notes:   reserved code leaves the address alone
`timescale 1ns/100ps
`default_nettype none
module dcc_step (
    input  wire logic [1:0]  mode,
    input  wire logic [31:0] cur_addr,
    output logic      [31:0] next_addr
);
    always_comb
    begin
        case (mode)
            dcc_pkg::CM_INC: next_addr = cur_addr + dcc_pkg::ADDR_STEP;
            dcc_pkg::CM_DEC: next_addr = cur_addr - dcc_pkg::ADDR_STEP;
            default:         next_addr = cur_addr;
        endcase
    end
endmodule // dcc_step
`default_nettype wire

// file: logic/dcc_channel.sv
// Purpose: one DMA channel with its control bits, APB slave and engine
// Assumes: one word per bus request; requester holds request until ack/err
// Notes:   register writes other than status and go are ignored while busy
// Behaviour
// - Chain done interrupt gated by bit 11
// - Core bus error interrupt gated by 10
// - System bus error interrupt gated by 9
// - Bit 7 picks source bus
// - Bit 3 picks destination bus
// - Source counting: fixed, reserved, up, down
// - Destination code 00 keeps address
// - Destination codes: reserved, up, down
// - Fixed side: no bursts, one word
// - Controls reset zero; reserved bits read zero
// - System error: finish, idle until cleared (code: waits in ST_HALT, still active, then resumes the transfer once cleared)
// - Core error: finish, idle until cleared (code: waits in ST_HALT, still active, then resumes the transfer once cleared)
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module dcc_channel #(
    parameter int unsigned DEPTH = dcc_pkg::FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             src_req,
    output logic      [31:0] src_addr,
    output logic             src_sys_bus,
    output logic             src_burst_ok,
    input  wire logic        src_ack,
    input  wire logic        src_err,
    input  wire logic [31:0] src_rdata,
    output logic             dst_req,
    output logic      [31:0] dst_addr,
    output logic             dst_sys_bus,
    output logic             dst_burst_ok,
    output logic      [31:0] dst_wdata,
    input  wire logic        dst_ack,
    input  wire logic        dst_err,
    output logic             irq
);
    localparam int unsigned CW = dcc_pkg::CNT_W;
    dcc_pkg::dcc_state_type state_q;
    logic [31:0]            ctrl_q;
    logic [31:0]            src_addr_q;
    logic [31:0]            dst_addr_q;
    logic [31:0]            src_next;
    logic [31:0]            dst_next;
    logic [CW-1:0]          cnt_q;
    logic [CW-1:0]          rd_left_q;
    logic [CW-1:0]          wr_left_q;
    logic                   src_req_q;
    logic                   src_sys_q;
    logic                   dst_req_q;
    logic                   dst_sys_q;
    logic [31:0]            dst_wdata_q;
    logic                   dst_retry_q;
    logic                   sys_err_q;
    logic                   core_err_q;
    logic                   chain_q;
    logic                   cfg_err_q;
    logic                   irq_q;
    logic                   src_burst_q;
    logic                   dst_burst_q;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   acc;
    logic                   wr_en;
    logic                   idle;
    logic                   err_any;
    logic                   src_done;
    logic                   dst_done;
    logic                   src_issue;
    logic                   dst_issue;
    logic                   go;
    logic                   go_ok;
    logic                   stat_wr;
    logic [1:0]             src_mode;
    logic [1:0]             dst_mode;
    logic                   set_sys;
    logic                   set_core;

    dcc_fifo_if #(.W(32)) fq ();

    function automatic logic mode_ok(input logic [1:0] m);
        mode_ok = (m != dcc_pkg::CM_RSVD);
    endfunction

    function automatic logic mode_moves(input logic [1:0] m);
        mode_moves = (m == dcc_pkg::CM_INC) || (m == dcc_pkg::CM_DEC);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    assign src_mode = ctrl_q[dcc_pkg::B_SRC_CM +: 2];
    assign dst_mode = ctrl_q[dcc_pkg::B_DST_CM +: 2];
    assign acc      = psel & penable & pready_q;
    assign wr_en    = acc & pwrite;
    assign idle     = (state_q == dcc_pkg::ST_IDLE);
    assign err_any  = sys_err_q | core_err_q;
    assign stat_wr  = wr_en && hit(paddr, dcc_pkg::A_STAT);
    assign go       = wr_en && hit(paddr, dcc_pkg::A_GO) && pwdata[dcc_pkg::B_GO];
    assign go_ok    = idle && (cnt_q != '0) && mode_ok(src_mode) && mode_ok(dst_mode);
    assign src_done = src_req_q & (src_ack | src_err);
    assign dst_done = dst_req_q & (dst_ack | dst_err);
    // no new work while an error is pending
    assign src_issue = (state_q == dcc_pkg::ST_RUN) && !src_req_q && !err_any
                       && (rd_left_q != '0) && fq.in_ready;
    // same stall for either bus error
    assign dst_issue = (state_q == dcc_pkg::ST_RUN) && !dst_req_q && !err_any
                       && (dst_retry_q || fq.out_valid);
    assign fq.in_valid  = src_req_q & src_ack;
    assign fq.in_data   = src_rdata;
    assign fq.out_ready = dst_issue & ~dst_retry_q;
    // errors are filed against the bus the failing side used
    assign set_sys  = (src_req_q & src_err & src_sys_q) | (dst_req_q & dst_err & dst_sys_q);
    assign set_core = (src_req_q & src_err & ~src_sys_q) | (dst_req_q & dst_err & ~dst_sys_q);

    dcc_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo
    (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (fq.fifo)
    );

    dcc_step u_src_step
    (
        .mode      (src_mode),
        .cur_addr  (src_addr_q),
        .next_addr (src_next)
    );

    dcc_step u_dst_step
    (
        .mode      (dst_mode),
        .cur_addr  (dst_addr_q),
        .next_addr (dst_next)
    );

    // APB handshake: one wait state, then answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= 1'b0;
            if (psel && penable && !pready_q)
            begin
                case (paddr)
                    dcc_pkg::A_CTRL: prdata_q <= ctrl_q & dcc_pkg::CTRL_MASK;
                    dcc_pkg::A_SRC:  prdata_q <= src_addr_q;
                    dcc_pkg::A_DST:  prdata_q <= dst_addr_q;
                    dcc_pkg::A_CNT:  prdata_q <= 32'(wr_left_q | (idle ? cnt_q : '0));
                    dcc_pkg::A_STAT:
                    begin
                        prdata_q                     <= '0;
                        prdata_q[dcc_pkg::S_SYS_ERR] <= sys_err_q;
                        prdata_q[dcc_pkg::S_CORE_ERR]<= core_err_q;
                        prdata_q[dcc_pkg::S_CHAIN]   <= chain_q;
                        prdata_q[dcc_pkg::S_CFG_ERR] <= cfg_err_q;
                        prdata_q[dcc_pkg::S_ACT]     <= ~idle;
                    end
                    dcc_pkg::A_GO:   prdata_q <= '0;
                    default:
                    begin
                        prdata_q  <= '0;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= dcc_pkg::CTRL_RESET;
        else if (wr_en && idle && hit(paddr, dcc_pkg::A_CTRL))
            ctrl_q <= pwdata & dcc_pkg::CTRL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (wr_en && idle && hit(paddr, dcc_pkg::A_CNT))
            cnt_q <= pwdata[dcc_pkg::CNT_W-1:0];
    end

    // Status flags: hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_err_q  <= 1'b0;
            core_err_q <= 1'b0;
            chain_q    <= 1'b0;
            cfg_err_q  <= 1'b0;
        end
        else
        begin
            if (set_sys)
                sys_err_q <= 1'b1;
            else if (stat_wr && !pwdata[dcc_pkg::S_SYS_ERR])
                sys_err_q <= 1'b0;
            if (set_core)
                core_err_q <= 1'b1;
            else if (stat_wr && !pwdata[dcc_pkg::S_CORE_ERR])
                core_err_q <= 1'b0;
            if (dst_req_q && dst_ack && wr_left_q == dcc_pkg::CNT_W'(1))
                chain_q <= 1'b1;
            else if (stat_wr && !pwdata[dcc_pkg::S_CHAIN])
                chain_q <= 1'b0;
            if (go && !go_ok)
                cfg_err_q <= 1'b1;
            else if (stat_wr && !pwdata[dcc_pkg::S_CFG_ERR])
                cfg_err_q <= 1'b0;
        end
    end

    // Channel sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= dcc_pkg::ST_IDLE;
        else
        begin
            case (state_q)
                dcc_pkg::ST_IDLE:
                begin
                    if (go && go_ok)
                        state_q <= dcc_pkg::ST_RUN;
                end
                dcc_pkg::ST_RUN:
                begin
                    if (dst_req_q && dst_ack && wr_left_q == dcc_pkg::CNT_W'(1))
                        state_q <= dcc_pkg::ST_IDLE;
                    // pending transfers end before the halt
                    else if (err_any && !(src_req_q && !src_done) && !(dst_req_q && !dst_done))
                        state_q <= dcc_pkg::ST_HALT;
                end
                dcc_pkg::ST_HALT:
                begin
                    // stays halted until both flags are clear
                    if (!err_any)
                        state_q <= dcc_pkg::ST_RUN;
                end
                default: state_q <= dcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Source side: one read outstanding; FIFO space checked at issue
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_req_q  <= 1'b0;
            src_sys_q  <= 1'b0;
            src_addr_q <= '0;
            rd_left_q  <= '0;
        end
        else
        begin
            if (wr_en && idle && hit(paddr, dcc_pkg::A_SRC))
                src_addr_q <= pwdata;
            if (go && go_ok)
                rd_left_q <= cnt_q;
            if (src_issue)
            begin
                src_req_q <= 1'b1;
                src_sys_q <= ctrl_q[dcc_pkg::B_SRC_SYS];
            end
            else if (src_done)
            begin
                src_req_q <= 1'b0;
                if (src_ack)
                begin
                    // address moves only on a good word
                    src_addr_q <= src_next;
                    rd_left_q  <= rd_left_q - 1'b1;
                end
            end
        end
    end

    // Destination side: failed word kept and retried after the halt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dst_req_q   <= 1'b0;
            dst_sys_q   <= 1'b0;
            dst_addr_q  <= '0;
            dst_wdata_q <= '0;
            dst_retry_q <= 1'b0;
            wr_left_q   <= '0;
        end
        else
        begin
            if (wr_en && idle && hit(paddr, dcc_pkg::A_DST))
                dst_addr_q <= pwdata;
            if (go && go_ok)
                wr_left_q <= cnt_q;
            if (dst_issue)
            begin
                dst_req_q <= 1'b1;
                dst_sys_q <= ctrl_q[dcc_pkg::B_DST_SYS];
                if (!dst_retry_q)
                    dst_wdata_q <= fq.out_data;
            end
            else if (dst_done)
            begin
                dst_req_q   <= 1'b0;
                dst_retry_q <= dst_err;
                if (dst_ack)
                begin
                    // up or down for memory, still for I/O
                    dst_addr_q <= dst_next;
                    wr_left_q  <= wr_left_q - 1'b1;
                end
            end
        end
    end

    // Burst permission and interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_burst_q <= 1'b0;
            dst_burst_q <= 1'b0;
            irq_q       <= 1'b0;
        end
        else
        begin
            src_burst_q <= mode_moves(src_mode);
            dst_burst_q <= mode_moves(dst_mode);
            irq_q <= (chain_q & ctrl_q[dcc_pkg::B_CHAIN_IE])   // chain gate
                   | (core_err_q & ctrl_q[dcc_pkg::B_CORE_IE]) // core gate
                   | (sys_err_q & ctrl_q[dcc_pkg::B_SYS_IE]);  // system gate
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign src_req      = src_req_q;
    assign src_addr     = src_addr_q;
    assign src_sys_bus  = src_sys_q;
    assign src_burst_ok = src_burst_q;
    assign dst_req      = dst_req_q;
    assign dst_addr     = dst_addr_q;
    assign dst_sys_bus  = dst_sys_q;
    assign dst_burst_ok = dst_burst_q;
    assign dst_wdata    = dst_wdata_q;
    assign irq          = irq_q;
endmodule // dcc_channel
`default_nettype wire

// file: verification/dcc_properties.sv
// Purpose: port assertions of the DMA channel
// Assumes: CTRL written only while idle
// Notes:   CTRL rebuilt from APB; halt set by bus errors, cleared by a status write
`timescale 1ns/100ps
`default_nettype none
module dcc_channel_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        src_req,
    input wire logic [31:0] src_addr,
    input wire logic        src_sys_bus,
    input wire logic        src_burst_ok,
    input wire logic        src_ack,
    input wire logic        src_err,
    input wire logic        dst_req,
    input wire logic [31:0] dst_addr,
    input wire logic        dst_sys_bus,
    input wire logic        dst_burst_ok,
    input wire logic        dst_ack,
    input wire logic        dst_err,
    input wire logic        irq
);
    logic [31:0] ctrl_q;
    logic        halt_q;
    wire         wr_acc = psel && penable && pready && pwrite;

    function automatic logic [31:0] nxt(input logic [1:0] m, input logic [31:0] a);
        return m == 2'h2 ? a + 32'h4 : (m == 2'h3 ? a - 32'h4 : a);
    endfunction

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ctrl_q <= 32'h0;
        else if (wr_acc && paddr == dcc_pkg::A_CTRL) ctrl_q <= pwdata;

    // Clearing status is the only way out of an error halt
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) halt_q <= 1'b0;
        else if (wr_acc && paddr == dcc_pkg::A_STAT) halt_q <= 1'b0;
        else if ((src_req && src_err) || (dst_req && dst_err)) halt_q <= 1'b1;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_answer;
        !pready ##1 pready;
    endsequence

    chk_apb_wait: assert property (psel && penable && !$past(penable) |-> s_answer)
        else $error("apb wait state wrong");
    chk_src_bus: assert property (src_req |-> src_sys_bus == ctrl_q[7])
        else $error("source bus select wrong");
    chk_dst_bus: assert property (dst_req |-> dst_sys_bus == ctrl_q[3])
        else $error("destination bus select wrong");
    chk_src_burst: assert property (src_req |-> src_burst_ok == (ctrl_q[5:4] != 2'h0))
        else $error("source burst permission wrong");
    chk_dst_burst: assert property (dst_req |-> dst_burst_ok == (ctrl_q[1:0] != 2'h0))
        else $error("destination burst permission wrong");
    chk_src_step: assert property (src_req && src_ack |=>
        src_addr == nxt(ctrl_q[5:4], $past(src_addr))) else $error("source step wrong");
    chk_dst_step: assert property (dst_req && dst_ack |=>
        dst_addr == nxt(ctrl_q[1:0], $past(dst_addr))) else $error("destination step wrong");
    chk_halt_quiet: assert property ($rose(src_req) || $rose(dst_req) |-> !$past(halt_q))
        else $error("request issued while halted");
    chk_irq_masked: assert property ((ctrl_q[11:9] == 3'h0) [*2] |-> !irq)
        else $error("irq while all enables clear");
endmodule // dcc_channel_properties

bind dcc_channel dcc_channel_properties u_dcc_channel_properties (.*);
`default_nettype wire

// file: verification/dcc_mem_model.sv
// Purpose: memories on both buses, answering channel requests
// Assumes: one outstanding request per side
// Notes:   lat adds wait cycles
`timescale 1ns/100ps
`default_nettype none
module dcc_mem_model #(parameter logic [31:0] KEY = 32'h5A5A_0000) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [1:0]  lat,
    input wire logic        fail_src,
    input wire logic        fail_dst,
    input wire logic        src_req,
    input wire logic [31:0] src_addr,
    output logic            src_ack,
    output logic            src_err,
    output logic     [31:0] src_rdata,
    input wire logic        dst_req,
    input wire logic [31:0] dst_addr,
    input wire logic        dst_sys_bus,
    input wire logic [31:0] dst_wdata,
    output logic            dst_ack,
    output logic            dst_err,
    output logic     [7:0]  n_wr,
    output logic     [31:0] wr_addr,
    output logic     [31:0] wr_data,
    output logic            wr_sys
);
    logic [1:0] sw_q;
    logic [1:0] dw_q;

    // Idle read data toggles so stale data shows
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            {src_ack, src_err, sw_q, src_rdata} <= '0;
        end
        else
        begin
            {src_ack, src_err} <= 2'h0;
            src_rdata <= ~src_rdata;
            if (src_req && !src_ack && !src_err)
                if (sw_q != lat) sw_q <= sw_q + 2'h1;
                else
                begin
                    sw_q <= 2'h0;
                    {src_ack, src_err} <= {!fail_src, fail_src};
                    src_rdata <= src_addr ^ KEY;
                end
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            {dst_ack, dst_err, dw_q, n_wr, wr_addr, wr_data, wr_sys} <= '0;
        end
        else
        begin
            {dst_ack, dst_err} <= 2'h0;
            if (dst_req && !dst_ack && !dst_err)
                if (dw_q != lat) dw_q <= dw_q + 2'h1;
                else
                begin
                    dw_q <= 2'h0;
                    {dst_ack, dst_err} <= {!fail_dst, fail_dst};
                    if (!fail_dst) {n_wr, wr_addr, wr_data, wr_sys} <=
                        {n_wr + 8'h1, dst_addr, dst_wdata, dst_sys_bus};
                end
        end
endmodule // dcc_mem_model
`default_nettype wire

// file: verification/testbench.sv
// Purpose: self-checking bench of the DMA channel
// Assumes: memory model answers both sides
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [31:0] SA  = 32'h0000_1000;
    localparam logic [31:0] DA  = 32'h0000_2000;
    localparam logic [31:0] KEY = 32'h5A5A_0000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_q;
    logic        src_req, src_sys_bus, src_burst_ok, src_ack, src_err, fail_src;
    logic        dst_req, dst_sys_bus, dst_burst_ok, dst_ack, dst_err, fail_dst, wr_sys;
    logic [1:0]  lat;
    logic [7:0]  paddr, n_wr, n0;
    logic [31:0] pwdata, prdata, src_addr, src_rdata, dst_addr, dst_wdata, wr_addr, wr_data, rd_q;
    int          error_cnt = 0;
    int          num_checks = 0;

    dcc_channel u_dcc_channel (.*);
    dcc_mem_model u_dcc_mem_model (.*);

    always #20 pclk = ~pclk;

    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        {rd_q, slv_q} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task run(input logic [31:0] c, input logic [31:0] cnt);
        n0 = n_wr;
        apb(1'b1, dcc_pkg::A_CTRL, c);
        apb(1'b1, dcc_pkg::A_SRC, SA);
        apb(1'b1, dcc_pkg::A_DST, DA);
        apb(1'b1, dcc_pkg::A_CNT, cnt);
        apb(1'b1, dcc_pkg::A_GO, 32'h1);
    endtask

    task wait_idle;
        repeat (40)
        begin
            apb(1'b0, dcc_pkg::A_STAT, 32'h0);
            if (rd_q[31] === 1'b0) break;
        end
    endtask

    function automatic logic [31:0] stp(input logic [1:0] m);
        return m == 2'h2 ? 32'h8 : (m == 2'h3 ? -32'h8 : 32'h0);
    endfunction

    task t_regs;
        apb(1'b0, dcc_pkg::A_CTRL, 32'h0); chk(rd_q, 32'h0);
        apb(1'b0, dcc_pkg::A_STAT, 32'h0); chk(rd_q, 32'h0);
        apb(1'b1, dcc_pkg::A_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, dcc_pkg::A_CTRL, 32'h0); chk(rd_q, 32'h0000_0EBB);
        apb(1'b0, 8'h3C, 32'h0); chk(slv_q, 1'b1);
        $display("test regs done");
    endtask

    task t_modes;
        logic [31:0] tab [4] = '{32'h0822, 32'h00BB, 32'h0882, 32'h0028};
        foreach (tab[i])
        begin
            lat <= i[1:0];
            run(tab[i], 32'h3);
            wait_idle;
            chk(n_wr, n0 + 8'h3);
            chk(wr_data, (SA + stp(tab[i][5:4])) ^ KEY);
            chk(wr_addr, DA + stp(tab[i][1:0]));
            chk(wr_sys, tab[i][3]);
            apb(1'b0, dcc_pkg::A_STAT, 32'h0); chk(rd_q[2], 1'b1);
            chk(irq, tab[i][11]);
            apb(1'b1, dcc_pkg::A_STAT, 32'h0);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
        end
        $display("test modes done");
    endtask

    task t_rsvd;
        logic [31:0] tab [2] = '{32'h0812, 32'h0821};
        foreach (tab[i])
        begin
            run(tab[i], 32'h2);
            repeat (5) @(posedge pclk);
            apb(1'b0, dcc_pkg::A_STAT, 32'h0);
            chk({rd_q[31], rd_q[3]}, 2'b01);
            chk(n_wr, n0);
            apb(1'b1, dcc_pkg::A_STAT, 32'h0);
        end
        $display("test reserved done");
    endtask

    task t_err;
        logic [31:0] tab [3] = '{32'h02A2, 32'h0022, 32'h0422};
        logic [3:0]  exp [3] = '{4'b1010, 4'b0101, 4'b1100};
        foreach (tab[i])
        begin
            {fail_src, fail_dst} <= {!exp[i][0], exp[i][0]};
            run(tab[i], 32'h2);
            while (src_err !== 1'b1 && dst_err !== 1'b1) @(posedge pclk);
            {fail_src, fail_dst} <= 2'b00;
            repeat (20) @(posedge pclk);
            apb(1'b0, dcc_pkg::A_STAT, 32'h0); chk(rd_q[1:0], exp[i][2:1]);
            chk(n_wr, n0);
            chk(irq, exp[i][3]);
            apb(1'b1, dcc_pkg::A_STAT, 32'h0);
            wait_idle;
            chk(n_wr, n0 + 8'h2);
        end
        $display("test errors done");
    endtask

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {lat, fail_src, fail_dst} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_modes;
        t_rsvd;
        t_err;
        report_and_stop;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
